// *** logic/aipac_pkg.sv ***
// Package: constants and types of the audio input port and configuration
package aipac_pkg;

  // Input formats, selected by a two-bit field
  localparam logic [1:0] FMT_I2S   = 2'h0;
  localparam logic [1:0] FMT_TDM   = 2'h1;
  localparam logic [1:0] FMT_RJ    = 2'h2;
  localparam logic [1:0] FMT_LJ    = 2'h3;

  // Configuration register addresses (for reference by the host model)
  localparam logic [7:0] ADDR_SWITCH_CTRL = 8'h02;
  localparam logic [7:0] ADDR_FORMAT_CTRL = 8'h33;
  localparam logic [7:0] ADDR_WORD_LEN    = 8'h34;
  localparam logic [7:0] ADDR_LOOP_CTRL   = 8'h53;
  localparam logic [7:0] ADDR_AGAIN       = 8'h54;
  localparam logic [7:0] ADDR_GPIO_FIRST  = 8'h60;
  localparam logic [7:0] ADDR_GPIO_LAST   = 8'h64;
  localparam logic [7:0] ADDR_FAULT_STAT  = 8'h71;

  // Field positions
  localparam int FMT_LSB      = 4;
  localparam int FSW_LSB      = 4;
  localparam int BRIDGE_BIT   = 2;
  localparam int LOOPBW_LSB   = 5;
  localparam int WLEN_HI_BIT  = 7;

  // Reset values: I2S, 24-bit word
  localparam logic [1:0] FMT_RESET  = FMT_I2S;
  localparam logic [8:0] WLEN_RESET = 9'h018;
  localparam logic [8:0] WLEN_MAX   = 9'h020;
  localparam logic [7:0] VOLUME_RESET = 8'h00;
  localparam logic [7:0] BOOST_DB     = 8'h00;

  // Clock halt timeout in microseconds and its count of system cycles
  localparam int CLK_MHZ        = 25;
  localparam int HALT_TIMEOUT_US = 100;
  localparam int HALT_CYCLES    = HALT_TIMEOUT_US * CLK_MHZ;

  // Rate detector: system cycles per word period at band boundaries
  localparam int RATE_32K_MIN  = 650;
  localparam int RATE_48K_MIN  = 470;
  localparam int RATE_96K_MIN  = 235;

  typedef enum logic [1:0]
  {
    RATE_NONE,
    RATE_32K,
    RATE_48K,
    RATE_96K
  } aipac_rate_t;

  // One received stereo sample
  typedef struct packed
  {
    logic [31:0] left;
    logic [31:0] right;
  } aipac_sample_t;

  // Configuration fields as written by software: four bytes and a five-bit gain code
  typedef struct packed
  {
    logic [7:0] switch_ctrl;
    logic [7:0] format_ctrl;
    logic [7:0] word_len;
    logic [7:0] loop_ctrl;
    logic [4:0] again;
  } aipac_cfg_t;

endpackage

// *** logic/aipac_top.sv ***
// Serial audio input port with clock supervision and amplifier settings
// Function
// - On clock halt, set outputs_hiz_o and raise the clock error flag.
// - When clocks return, resume the previous state without software help.
// - Format field bits 5:4 picks I2S, left, right justified or TDM.
// - Samples are two's complement, MSB first, up to 32 bits.
// - Word length comes from bit 7 plus eight bits of the length byte.
// - Reset defaults are I2S format and 24-bit words.
// - I2S: word clock low is left, high is right.
// - Right justified: word clock high is left, low is right.
// - TDM frame starts on frame sync rising edge; sync lasts a bit.
// - Switching frequency code comes from bits 6:4 of the switch byte.
// - Gain code 0 to 31 gives 0 to -15.5 dB; boost stays 0 dB.
// - Digital volume defaults to 0 dB.
// - Loop bandwidth code comes from bits 6:5 of the loop byte.
// - Bridge bit 2 picks stereo or parallel bridge output.
// - A general pin can serve as EEPROM serial data in; serial out and clock are not routed.
// - Unsupported bit to word clock ratio also raises the error flag.
// - Rate detector reports 32, 44.1-48 or 88.2-96 kHz band.
module aipac_top
  import aipac_pkg::*;
#(
  parameter int HALT_CNT = HALT_CYCLES
)
(
  input  wire logic          clock_i,
  input  wire logic          rstn_i,
  input  wire logic          ce_i,
  input  wire logic          bit_clock_i,
  input  wire logic          word_clock_frame_sync_i,
  input  wire logic          serial_audio_in_i,
  input  wire aipac_cfg_t    cfg_i,
  input  wire logic          play_req_i,
  input  wire logic [2:0]    spi_pin_sel_i,
  input  wire logic          spi_data_in_pin_i,
  output logic               spi_data_in_o,
  output logic               clock_error_o,
  output logic               outputs_hiz_o,
  output logic               playing_o,
  output aipac_rate_t        rate_o,
  output aipac_sample_t      sample_o,
  output logic               sample_valid_o,
  output logic [1:0]         format_o,
  output logic [8:0]         word_len_o,
  output logic [2:0]         switch_freq_o,
  output logic [1:0]         loop_bw_o,
  output logic               parallel_bridge_output_o,
  output logic [5:0]         gain_half_db_o,
  output logic [7:0]         volume_o,
  output logic [7:0]         boost_o
);

  function automatic logic [8:0] clamp_len(input logic [8:0] len);
    clamp_len = (len == 9'h000 || len > WLEN_MAX) ? WLEN_MAX : len;
  endfunction

  // Left-aligns a slot's word; bits past the word length are cleared
  function automatic logic [31:0] align_word(input logic [31:0] raw,
                                             input logic [5:0]  got,
                                             input logic [1:0]  fmt,
                                             input logic [8:0]  wlen);
    logic [31:0] word;
    if (fmt == FMT_RJ)
      word = raw << (6'd32 - wlen[5:0]);
    else if (fmt == FMT_I2S)
      word = raw << (6'd33 - got);
    else
      word = raw << (6'd32 - got);
    align_word = word & ~(32'hFFFFFFFF >> wlen[5:0]);
  endfunction

  // Link domain: shift register and frame logic on the bit clock
  logic [1:0]  fmt_lk_sync_reg;
  logic [1:0]  fmt_lk_reg;
  logic [8:0]  wlen_lk_sync_reg;
  logic [8:0]  wlen_lk_reg;
  logic        wclk_prev_reg;
  logic [5:0]  bit_cnt_reg;
  logic [31:0] shift_reg;
  logic [31:0] left_lk_reg;
  logic [31:0] right_lk_reg;
  logic        word_tgl_reg;
  logic [9:0]  bits_per_frame_reg;
  logic [9:0]  frame_len_reg;
  logic        left_now;
  logic        edge_start;

  // Format is quasi-static; synchronised into link domain anyway
  always_ff @(posedge bit_clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fmt_lk_sync_reg  <= FMT_RESET;
      fmt_lk_reg       <= FMT_RESET;
      wlen_lk_sync_reg <= WLEN_RESET;
      wlen_lk_reg      <= WLEN_RESET;
    end
    else
    begin
      fmt_lk_sync_reg  <= format_o;
      fmt_lk_reg       <= fmt_lk_sync_reg;
      // Length is static while clocks run; a change mid-frame may garble
      wlen_lk_sync_reg <= word_len_o;
      wlen_lk_reg      <= wlen_lk_sync_reg;
    end
  end

  always_comb
  begin
    left_now   = (fmt_lk_reg == FMT_RJ) ? word_clock_frame_sync_i
                                        : !word_clock_frame_sync_i;
    edge_start = (fmt_lk_reg == FMT_TDM)
                 ? (word_clock_frame_sync_i && !wclk_prev_reg)
                 : (word_clock_frame_sync_i != wclk_prev_reg);
  end

  always_ff @(posedge bit_clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wclk_prev_reg      <= 1'b0;
      bit_cnt_reg        <= 6'h00;
      shift_reg          <= 32'h00000000;
      left_lk_reg        <= 32'h00000000;
      right_lk_reg       <= 32'h00000000;
      word_tgl_reg       <= 1'b0;
      bits_per_frame_reg <= 10'h000;
      frame_len_reg      <= 10'h000;
    end
    else
    begin
      wclk_prev_reg <= word_clock_frame_sync_i;
      bits_per_frame_reg <= bits_per_frame_reg + 10'h001;
      if (edge_start)
      begin
        // Slot ends: MSB-first word, left-aligned to 32 bits
        bit_cnt_reg <= 6'h01;
        shift_reg   <= {31'h0, serial_audio_in_i};
        if (fmt_lk_reg == FMT_TDM || !left_now)
          left_lk_reg <= align_word(shift_reg, bit_cnt_reg,
                                    fmt_lk_reg, wlen_lk_reg);
        else
          right_lk_reg <= align_word(shift_reg, bit_cnt_reg,
                                     fmt_lk_reg, wlen_lk_reg);
        if (fmt_lk_reg == FMT_TDM || left_now)
        begin
          word_tgl_reg       <= ~word_tgl_reg;
          frame_len_reg      <= bits_per_frame_reg + 10'h001;
          bits_per_frame_reg <= 10'h000;
        end
      end
      else
      begin
        // Right-justified keeps shifting so the tail of the slot wins
        if (fmt_lk_reg == FMT_RJ || bit_cnt_reg < 6'd32)
          shift_reg <= {shift_reg[30:0], serial_audio_in_i};
        if (bit_cnt_reg < 6'd32)
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end
  end

  // Crossing: toggle synchronised, words sampled once it settles
  logic [2:0]  tgl_sync_reg;
  logic        edge_sync1_reg;
  logic        edge_sync2_reg;
  logic        edge_prev_reg;
  logic [31:0] idle_cnt_reg;
  logic [15:0] period_cnt_reg;
  logic        halted_reg;
  logic        ratio_bad_reg;
  logic        first_word_reg;
  logic [1:0]  fmt_next;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tgl_sync_reg   <= 3'h0;
      edge_sync1_reg <= 1'b0;
      edge_sync2_reg <= 1'b0;
      edge_prev_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      tgl_sync_reg   <= {tgl_sync_reg[1:0], word_tgl_reg};
      edge_sync1_reg <= wclk_prev_reg;
      edge_sync2_reg <= edge_sync1_reg;
      edge_prev_reg  <= edge_sync2_reg;
    end
  end

  logic word_evt;
  logic link_evt;
  assign word_evt = tgl_sync_reg[2] != tgl_sync_reg[1];
  assign link_evt = edge_sync2_reg != edge_prev_reg;

  // Halt watchdog counted on the system clock
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      idle_cnt_reg <= 32'h00000000;
      halted_reg   <= 1'b1;
    end
    else if (ce_i)
    begin
      if (link_evt)
      begin
        idle_cnt_reg <= 32'h00000000;
        halted_reg   <= 1'b0;
      end
      else if (idle_cnt_reg >= 32'(HALT_CNT - 1))
        halted_reg <= 1'b1;
      else
        idle_cnt_reg <= idle_cnt_reg + 32'h00000001;
    end
  end

  // Word period measurement for the rate detector and ratio check
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      period_cnt_reg <= 16'h0000;
      rate_o         <= RATE_NONE;
      ratio_bad_reg  <= 1'b0;
      first_word_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      if (halted_reg)
      begin
        period_cnt_reg <= 16'h0000;
        rate_o         <= RATE_NONE;
        ratio_bad_reg  <= 1'b0;
        first_word_reg <= 1'b1;
      end
      else if (word_evt)
      begin
        period_cnt_reg <= 16'h0000;
        first_word_reg <= 1'b0;
        // First word after a halt spans a partial frame: not judged
        if (!first_word_reg)
        begin
          if (period_cnt_reg >= 16'(RATE_32K_MIN))
            rate_o <= RATE_32K;
          else if (period_cnt_reg >= 16'(RATE_48K_MIN))
            rate_o <= RATE_48K;
          else if (period_cnt_reg >= 16'(RATE_96K_MIN))
            rate_o <= RATE_96K;
          else
            rate_o <= RATE_NONE;
          // Supported bits per frame: 32, 64, 128, 256, 512
          case (frame_len_reg)
            10'd32, 10'd64, 10'd128, 10'd256, 10'd512:
              ratio_bad_reg <= 1'b0;
            default:
              ratio_bad_reg <= 1'b1;
          endcase
        end
      end
      else if (period_cnt_reg != 16'hFFFF)
        period_cnt_reg <= period_cnt_reg + 16'h0001;
    end
  end

  // Sample handoff; stable for half a frame after the toggle
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sample_o       <= '0;
      sample_valid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sample_valid_o <= word_evt && !halted_reg;
      if (word_evt)
        sample_o <= '{left: left_lk_reg, right: right_lk_reg};
    end
  end

  // Supervision: error flag and output state follow the clocks
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clock_error_o <= 1'b1;
      outputs_hiz_o <= 1'b1;
      playing_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      clock_error_o <= halted_reg || ratio_bad_reg;
      // Hi-Z while halted; play request is kept, so recovery is automatic
      outputs_hiz_o <= halted_reg || ratio_bad_reg || !play_req_i;
      playing_o     <= !halted_reg && !ratio_bad_reg && play_req_i;
    end
  end

  // Configuration decode
  always_comb
  begin
    fmt_next = cfg_i.format_ctrl[FMT_LSB +: 2];
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      format_o   <= FMT_RESET;
      word_len_o <= WLEN_RESET;
    end
    else if (ce_i)
    begin
      format_o   <= fmt_next;
      word_len_o <= clamp_len({cfg_i.format_ctrl[WLEN_HI_BIT],
                               cfg_i.word_len});
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      switch_freq_o            <= 3'h0;
      loop_bw_o                <= 2'h0;
      parallel_bridge_output_o <= 1'b0;
      gain_half_db_o           <= 6'h00;
      volume_o                 <= VOLUME_RESET;
      boost_o                  <= BOOST_DB;
    end
    else if (ce_i)
    begin
      switch_freq_o <= cfg_i.switch_ctrl[FSW_LSB +: 3];
      loop_bw_o     <= cfg_i.loop_ctrl[LOOPBW_LSB +: 2];
      parallel_bridge_output_o <= cfg_i.switch_ctrl[BRIDGE_BIT];
      // Attenuation in half-dB units: code 31 is 15.5 dB
      gain_half_db_o <= {1'b0, cfg_i.again};
      volume_o       <= VOLUME_RESET;
      boost_o        <= BOOST_DB;
    end
  end

  // EEPROM data-in pin routing; chip select is left to the host
  logic spi_sync1_reg;
  logic spi_sync2_reg;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      spi_sync1_reg <= 1'b0;
      spi_sync2_reg <= 1'b0;
      spi_data_in_o <= 1'b0;
    end
    else if (ce_i)
    begin
      spi_sync1_reg <= spi_data_in_pin_i;
      spi_sync2_reg <= spi_sync1_reg;
      spi_data_in_o <= (spi_pin_sel_i != 3'h0) && spi_sync2_reg;
    end
  end

endmodule // aipac_top

// *** verification/aipac_host_model.sv ***
// Host model driving bit clock, word clock and serial data
module aipac_host_model
  import aipac_pkg::*;
(
  output logic bit_clock_o,
  output logic word_clock_o,
  output logic serial_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    bit_clock_o  = 1'h0;
    word_clock_o = 1'h0;
    serial_o     = 1'h0;
  end

  // One frame of 64 bit clocks: two 32-bit slots of 24-bit words
  task automatic send_frame(input logic [1:0]  fmt,
                            input logic [23:0] lft,
                            input logic [23:0] rgt);
    logic [63:0] bits;
    bits = (fmt == FMT_RJ) ? {8'h00, lft, 8'h00, rgt}
                           : {1'h0, lft, 7'h00, 1'h0, rgt, 7'h00};
    for (int i = 0; i < 64; i++)
    begin
      word_clock_o = (fmt == FMT_RJ) ? (i < 32) : (i >= 32);
      serial_o = bits[63 - i];
      #3 bit_clock_o = 1'h1;
      #3 bit_clock_o = 1'h0;
    end
    // Bit clock stands still; data line no longer holds a valid bit
    serial_o = !serial_o;
  endtask
endmodule // aipac_host_model

// *** verification/aipac_props.sv ***
// Checker for the audio input port: halt, recovery and settings
module aipac_props
  import aipac_pkg::*;
#(
  parameter int HALT_CNT = HALT_CYCLES
)
(
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic       ce_i,
  input wire logic       word_clock_frame_sync_i,
  input wire aipac_cfg_t cfg_i,
  input wire logic       play_req_i,
  input wire logic       clock_error_o,
  input wire logic       outputs_hiz_o,
  input wire logic       playing_o,
  input wire logic       sample_valid_o,
  input wire logic [1:0] format_o,
  input wire logic [8:0] word_len_o,
  input wire logic [2:0] switch_freq_o,
  input wire logic [1:0] loop_bw_o,
  input wire logic       parallel_bridge_output_o,
  input wire logic [5:0] gain_half_db_o
);
  logic [1:0]  wc_sync_reg;
  logic [15:0] still_reg;
  logic [8:0]  wl_raw;
  logic [8:0]  wl_exp;

  assign wl_raw = {cfg_i.format_ctrl[7], cfg_i.word_len};
  assign wl_exp = (wl_raw == 9'h000 || wl_raw > WLEN_MAX) ? WLEN_MAX : wl_raw;

  // Cycles since the word clock last moved; saturates
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wc_sync_reg <= 2'h0;
      still_reg   <= 16'h0000;
    end
    else
    begin
      wc_sync_reg <= {wc_sync_reg[0], word_clock_frame_sync_i};
      if (wc_sync_reg[1] != wc_sync_reg[0])
        still_reg <= 16'h0000;
      else if (still_reg != 16'hFFFF)
        still_reg <= still_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // Margin of 8 covers both synchronisers and the two-cycle tri-state lag
  a_halt_detect: assert property (int'(still_reg) == HALT_CNT + 8
    |-> clock_error_o && outputs_hiz_o) else $error("halt not flagged");
  a_halt_quiet: assert property (still_reg > 16'h0010
    |-> !sample_valid_o) else $error("sample while halted");
  a_recover_play: assert property ($fell(clock_error_o) && play_req_i
    |-> ##[0:6] (playing_o && !outputs_hiz_o)) else $error("no recovery");
  a_format_sel: assert property (ce_i
    |=> format_o == $past(cfg_i.format_ctrl[5:4])) else $error("format");
  a_word_len: assert property (ce_i
    |=> word_len_o == $past(wl_exp)) else $error("word length");
  a_switch_freq: assert property (ce_i
    |=> switch_freq_o == $past(cfg_i.switch_ctrl[6:4])) else $error("fsw");
  a_loop_bw: assert property (ce_i
    |=> loop_bw_o == $past(cfg_i.loop_ctrl[6:5])) else $error("loop bw");
  a_bridge_sel: assert property (ce_i
    |=> parallel_bridge_output_o == $past(cfg_i.switch_ctrl[2]))
    else $error("bridge select");
  a_gain_code: assert property (ce_i
    |=> gain_half_db_o == {1'h0, $past(cfg_i.again)}) else $error("gain");

  c_sample: cover property (sample_valid_o);
  c_halt: cover property ($rose(clock_error_o));
  c_recover: cover property ($fell(clock_error_o));
endmodule // aipac_props

bind aipac_top aipac_props #(.HALT_CNT(HALT_CNT)) i_aipac_props (.*);

// *** verification/aipac_tb_top.sv ***
// Testbench for the audio input port with clock supervision
module aipac_tb_top import aipac_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [23:0] LEFT_W  = 24'hA5C3F1;
  localparam logic [23:0] RIGHT_W = 24'h3C5A96;

  typedef struct packed
  {
    aipac_cfg_t cfg;
    logic       pin;
    logic [1:0] fmt;
    logic [8:0] wlen;
    logic [2:0] fsw;
    logic [1:0] bw;
    logic       par;
    logic [5:0] gain;
  } aipac_row_t;

  localparam aipac_row_t ROWS [6] = '{
    '{'{8'h00,8'h00,8'h18,8'h00,5'h00},1'h1,2'h0,9'h018,3'h0,2'h0,1'h0,6'h00},
    '{'{8'hF5,8'h14,8'h10,8'h60,5'h1F},1'h0,2'h1,9'h010,3'h7,2'h3,1'h1,6'h1F},
    '{'{8'h30,8'h20,8'h00,8'h20,5'h01},1'h1,2'h2,9'h020,3'h3,2'h1,1'h0,6'h01},
    '{'{8'h44,8'hB0,8'h00,8'h40,5'h10},1'h0,2'h3,9'h020,3'h4,2'h2,1'h1,6'h10},
    '{'{8'h00,8'h00,8'h20,8'h00,5'h00},1'h1,2'h0,9'h020,3'h0,2'h0,1'h0,6'h00},
    '{'{8'h0B,8'h00,8'h21,8'h9F,5'h02},1'h0,2'h0,9'h020,3'h0,2'h0,1'h0,6'h02}
  };

  logic clock_i, rstn_i, ce_i, play_req_i, spi_data_in_pin_i;
  logic bit_clock_i, word_clock_frame_sync_i, serial_audio_in_i;
  logic [2:0] spi_pin_sel_i;
  aipac_cfg_t cfg_i;
  logic spi_data_in_o, clock_error_o, outputs_hiz_o, playing_o;
  logic sample_valid_o, parallel_bridge_output_o;
  logic [1:0] format_o, loop_bw_o;
  logic [8:0] word_len_o;
  logic [2:0] switch_freq_o;
  logic [5:0] gain_half_db_o;
  logic [7:0] volume_o, boost_o;
  aipac_sample_t sample_o, got;
  aipac_rate_t rate_o;
  int errors;
  int tests_run;

  aipac_top #(.HALT_CNT(50)) i_aipac_top (.*);
  aipac_host_model i_aipac_host_model (
    .bit_clock_o (bit_clock_i),
    .word_clock_o(word_clock_frame_sync_i),
    .serial_o    (serial_audio_in_i)
  );

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_val(input string n, input logic [63:0] e,
                         input logic [63:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic run_frames(input logic [1:0] f);
    got = '0;
    repeat (5) i_aipac_host_model.send_frame(f, LEFT_W, RIGHT_W);
    repeat (8) @(negedge clock_i);
    chk_val("left", {LEFT_W, 8'h00}, got.left);
    chk_val("right", {RIGHT_W, 8'h00}, got.right);
  endtask

  always @(posedge clock_i)
    if (sample_valid_o === 1'h1)
      got <= sample_o;

  initial
  begin
    clock_i = 1'h0;
    forever #20 clock_i = !clock_i;
  end

  initial
  begin
    #100000;
    errors++;
    test_done();
  end

  initial
  begin
    errors = 0;
    tests_run = 0;
    rstn_i = 1'h0;
    ce_i = 1'h1;
    play_req_i = 1'h1;
    spi_pin_sel_i = 3'h1;
    spi_data_in_pin_i = 1'h0;
    cfg_i = ROWS[0].cfg;
    repeat (5) @(negedge clock_i);
    chk_val("format", FMT_RESET, format_o);
    chk_val("word length", WLEN_RESET, word_len_o);
    chk_bit("tri-state", 1'h1, outputs_hiz_o);
    rstn_i = 1'h1;
    foreach (ROWS[k])
    begin
      cfg_i = ROWS[k].cfg;
      spi_data_in_pin_i = ROWS[k].pin;
      repeat (4) @(negedge clock_i);
      chk_val("format", ROWS[k].fmt, format_o);
      chk_val("word length", ROWS[k].wlen, word_len_o);
      chk_val("switch freq", ROWS[k].fsw, switch_freq_o);
      chk_val("loop bw", ROWS[k].bw, loop_bw_o);
      chk_bit("bridge", ROWS[k].par, parallel_bridge_output_o);
      chk_val("gain", ROWS[k].gain, gain_half_db_o);
      chk_val("volume", VOLUME_RESET, volume_o);
      chk_val("boost", BOOST_DB, boost_o);
      chk_bit("spi in", ROWS[k].pin, spi_data_in_o);
    end
    ce_i = 1'h0;
    cfg_i = ROWS[1].cfg;
    repeat (4) @(negedge clock_i);
    chk_val("frozen format", ROWS[5].fmt, format_o);
    ce_i = 1'h1;
    cfg_i = ROWS[0].cfg;
    @(negedge clock_i);
    run_frames(FMT_I2S);
    chk_val("rate", RATE_NONE, rate_o);
    chk_bit("clock error", 1'h0, clock_error_o);
    chk_bit("playing", 1'h1, playing_o);
    cfg_i.format_ctrl = 8'h20;
    @(negedge clock_i);
    run_frames(FMT_RJ);
    for (int t = 0; t < 200 && clock_error_o !== 1'h1; t++)
      @(negedge clock_i);
    chk_bit("clock error", 1'h1, clock_error_o);
    repeat (4) @(negedge clock_i);
    chk_bit("tri-state", 1'h1, outputs_hiz_o);
    chk_bit("playing", 1'h0, playing_o);
    run_frames(FMT_RJ);
    chk_bit("clock error", 1'h0, clock_error_o);
    chk_bit("tri-state", 1'h0, outputs_hiz_o);
    chk_bit("playing", 1'h1, playing_o);
    test_done();
  end
endmodule // aipac_tb_top
